//--- core/asu_uart.sv
// Asynchronous serial channel: registers, transmitter and receiver.
//
// The placing of the registers and strobed register access were decided locally.
`timescale 1ns/100ps
`default_nettype none

//Contract
// [RULE1] Transmit buffer write starts frame with start
// [RULE2] Start bit valid if low over half bit
// [RULE3] Frame sent raises transmit-complete pulse
// [RULE4] Start clears bit counter, completion raises pulse
// [RULE5] Transmitter and receiver run independently
// [RULE6] Software uses same frame, parity both ways
// [RULE7] Asynchronous mode ignores synchronous bit-count field
// [RULE8] Start, characters, parity, stops in order
// [RULE9] Frame field picks 7/8 bits, 1/2 stops
// [RULE10] Parity field: zero, one, odd, even
// [RULE11] Parity disable omits the parity bit
// [RULE12] Software picks MSB or LSB first
// [RULE13] Receive source: receive pin or transmit pin
// [RULE14] Single wire: direction bit switches transmit pin
// [RULE15] Completion copies shift data, sets full
// [RULE16] Reading receive buffer clears full flag
// [RULE17] Receive busy from start to completion
// [RULE18] Input disable clears receive busy at once
// [RULE19] Transmit busy spans chained frames until empty
// [RULE20] Output disable clears transmit busy at once
// [RULE21] Software sets clock master for communication
// [RULE22] Bit period is overflow times sixteen
// [RULE23] Line idles high, stops driven high
// [RULE24] Receiver samples bits near their middle
module asu_uart
(
   // Clock and reset
   input  wire logic                       clock_i,
   input  wire logic                       reset_i,
   // Register port
   input  wire logic [asu_pkg::ASU_AW-1:0] reg_addr_i,
   input  wire logic [asu_pkg::ASU_DW-1:0] reg_wdata_i,
   input  wire logic                       reg_wr_i,
   input  wire logic                       reg_rd_i,
   output logic      [asu_pkg::ASU_DW-1:0] reg_rdata_o,
   // Serial pins
   input  wire logic                       txd_i,
   output logic                            txd_o,
   output logic                            txd_oe_n_o,
   input  wire logic                       rxd_i,
   // Completion pulses
   output logic                            tx_complete_irq_o,
   output logic                            rx_complete_irq_o
);
   import asu_pkg::*;

   // ********************
   // Helpers
   // ********************
   // Reverses the character bits; a 7-bit character keeps bit 7 at zero.
   function automatic logic [7:0] asu_rev(input logic [7:0] d, input logic l8);
      logic [7:0] r;
      r = 8'h00;
      for (int i = 0; i < 8; i++)
      begin
         r[i] = d[7 - i];
      end
      asu_rev = l8 ? r : {1'b0, r[7:1]};
   endfunction : asu_rev

   // Bits following the start bit: characters, parity and stops.
   function automatic logic [3:0] asu_bits(input logic l8, input logic pe, input logic two);
      asu_bits = (l8 ? 4'h8 : 4'h7) + {3'h0, pe} + (two ? 4'h2 : 4'h1);
   endfunction : asu_bits

   // Builds the frame sent from bit 0 upward; all bits above are stops.
   function automatic logic [ASU_FRAME_W-1:0] asu_frame(input logic [7:0] w, input logic l8,
                                                        input logic pe, input logic pb);
      logic [ASU_FRAME_W-1:0] f;
      f      = {ASU_FRAME_W{1'b1}};
      f[0]   = 1'b0;
      f[7:1] = w[6:0];
      if (l8)
      begin
         f[8] = w[7];
      end
      if (pe)
      begin
         if (l8)
         begin
            f[9] = pb;
         end
         else
         begin
            f[8] = pb;
         end
      end
      asu_frame = f;
   endfunction : asu_frame

   // ********************
   // Registers and decode
   // ********************
   logic [7:0] mode0_r;
   logic [7:0] serial_mode_reg_one_r;
   logic [7:0] serial_mode_reg_two_r;
   logic [7:0] baud_r;
   logic [7:0] port_dir_r;
   logic [7:0] tx_data_buffer_r;
   logic [7:0] rx_data_buffer_r;
   logic [7:0] rdata_r;

   wire wr_tx    = reg_wr_i && (reg_addr_i == ADDR_TX_DATA);
   wire rd_rx    = reg_rd_i && (reg_addr_i == ADDR_RX_DATA);
   wire wr_mode0 = reg_wr_i && (reg_addr_i == ADDR_MODE0);
   wire wr_mode1 = reg_wr_i && (reg_addr_i == ADDR_MODE1);
   wire wr_mode2 = reg_wr_i && (reg_addr_i == ADDR_MODE2);
   wire wr_baud  = reg_wr_i && (reg_addr_i == ADDR_BAUD);
   wire wr_pdir  = reg_wr_i && (reg_addr_i == ADDR_PORT_DIR);

   // The synchronous bit-count field is stored for read-back only; the
   // frame length below never looks at it.
   wire [2:0] sync_bit_count_field = mode0_r[MODE0_SYNC_CNT_LSB +: 3];  // [RULE7]
   wire       first_lsb            = mode0_r[MODE0_FIRST_LSB];
   wire       comm_type_select     = serial_mode_reg_one_r[MODE1_COMM_TYPE];
   wire       clock_master_select  = serial_mode_reg_one_r[MODE1_CLK_MASTER];
   wire       serial_output_enable = serial_mode_reg_one_r[MODE1_OUT_EN];
   wire       serial_input_enable  = serial_mode_reg_one_r[MODE1_IN_EN];
   wire       input_source_select  = serial_mode_reg_one_r[MODE1_IN_SOURCE];
   wire       frame_mode_lo        = serial_mode_reg_two_r[MODE2_FRAME_LO];
   wire       frame_mode_hi        = serial_mode_reg_two_r[MODE2_FRAME_HI];
   wire       parity_mode_lo       = serial_mode_reg_two_r[MODE2_PARITY_LO];
   wire       parity_mode_hi       = serial_mode_reg_two_r[MODE2_PARITY_HI];
   wire       parity_disable       = serial_mode_reg_two_r[MODE2_PARITY_DIS];
   wire       port_direction_bit   = port_dir_r[PORT_DIR_TXD];

   wire char8    = frame_mode_hi;    // [RULE9]
   wire two_stop = frame_mode_lo;    // [RULE9]
   wire par_en   = ~parity_disable;  // [RULE11]
   wire [3:0] frame_bits = asu_bits(char8, par_en, two_stop);  // [RULE7]

   // Without the internal clock master the timer stands and nothing moves.
   wire link_run = comm_type_select & clock_master_select;  // [RULE21]

   always_ff @(posedge clock_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         mode0_r               <= MODE0_RST;
         serial_mode_reg_one_r <= MODE1_RST;
         serial_mode_reg_two_r <= MODE2_RST;
         baud_r                <= BAUD_RST;
         port_dir_r            <= PORT_DIR_RST;
         tx_data_buffer_r      <= 8'h00;
      end
      else
      begin
         mode0_r               <= wr_mode0 ? reg_wdata_i : mode0_r;
         serial_mode_reg_one_r <= wr_mode1 ? reg_wdata_i : serial_mode_reg_one_r;
         serial_mode_reg_two_r <= wr_mode2 ? reg_wdata_i : serial_mode_reg_two_r;
         baud_r                <= wr_baud ? reg_wdata_i : baud_r;
         port_dir_r            <= wr_pdir ? reg_wdata_i : port_dir_r;
         tx_data_buffer_r      <= wr_tx ? reg_wdata_i : tx_data_buffer_r;
      end
   end

   // ********************
   // Baud timer and pin synchronisers
   // ********************
   asu_baud_if baud_link ();

   assign baud_link.reload = baud_r;
   assign baud_link.run    = link_run;

   asu_baud u_baud
   (
      .clock_i (clock_i),
      .reset_i (reset_i),
      .baud    (baud_link.gen)
   );

   wire tick = baud_link.tick;

   logic [1:0] rxd_sync_r;
   logic [1:0] txd_sync_r;

   always_ff @(posedge clock_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         rxd_sync_r <= 2'b11;
         txd_sync_r <= 2'b11;
      end
      else
      begin
         rxd_sync_r <= {rxd_sync_r[0], rxd_i};
         txd_sync_r <= {txd_sync_r[0], txd_i};
      end
   end

   // In single-wire use the transmit pin is read back as receive data.
   wire serial_in = input_source_select ? txd_sync_r[1] : rxd_sync_r[1];  // [RULE13]

   // ********************
   // Transmitter
   // ********************
   asu_tx_state_e          tx_state_r;
   logic [ASU_FRAME_W-1:0] tx_frame_r;
   logic [3:0]             tx_left_r;
   logic [2:0]             tx_tick_r;
   logic                   tx_buffer_pending_flag_r;
   logic                   tx_busy_flag_r;
   logic                   tx_irq_r;
   logic                   txd_oe_n_r;

   wire [7:0] tx_char   = char8 ? tx_data_buffer_r : {1'b0, tx_data_buffer_r[6:0]};
   wire [7:0] tx_word   = first_lsb ? tx_char : asu_rev(tx_char, char8);  // [RULE12]
   wire       tx_xor    = ^tx_char;
   // Constant zero, constant one, odd, even over characters plus parity.
   wire       tx_pbit   = parity_mode_hi ? (parity_mode_lo ? tx_xor : ~tx_xor)
                                         : parity_mode_lo;  // [RULE10]
   wire [ASU_FRAME_W-1:0] tx_frame_new = asu_frame(tx_word, char8, par_en, tx_pbit);  // [RULE8]

   wire tx_shift  = (tx_state_r == TX_SHIFT);
   wire tx_bitend = tx_shift && tick && (tx_tick_r == TICK_LAST);
   wire tx_done   = tx_bitend && (tx_left_r == 4'h1);  // [RULE3]
   // A pending byte is taken at the end of a frame with no idle gap.
   wire tx_load   = tx_buffer_pending_flag_r && serial_output_enable && link_run
                    && ((tx_state_r == TX_IDLE) || tx_done);  // [RULE1]

   always_ff @(posedge clock_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         tx_state_r <= TX_IDLE;
         tx_frame_r <= {ASU_FRAME_W{1'b1}};
         tx_left_r  <= 4'h0;
         tx_tick_r  <= 3'h0;
      end
      else if (!serial_output_enable)
      begin
         tx_state_r <= TX_IDLE;
         tx_frame_r <= {ASU_FRAME_W{1'b1}};  // [RULE23]
         tx_left_r  <= 4'h0;
         tx_tick_r  <= 3'h0;
      end
      else if (tx_load)
      begin
         tx_state_r <= TX_SHIFT;
         tx_frame_r <= tx_frame_new;  // [RULE1]
         tx_left_r  <= frame_bits + 4'h1;
         tx_tick_r  <= 3'h0;
      end
      else if (tx_done)
      begin
         tx_state_r <= TX_IDLE;
         tx_frame_r <= {ASU_FRAME_W{1'b1}};  // [RULE23]
         tx_left_r  <= 4'h0;
         tx_tick_r  <= 3'h0;
      end
      else if (tx_shift && tick)
      begin
         tx_tick_r <= tx_tick_r + 3'h1;
         if (tx_bitend)
         begin
            tx_frame_r <= {1'b1, tx_frame_r[ASU_FRAME_W-1:1]};  // [RULE8]
            tx_left_r  <= tx_left_r - 4'h1;
         end
      end
   end

   // A new write wins over the load that consumes the previous byte.
   always_ff @(posedge clock_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         tx_buffer_pending_flag_r <= 1'b0;
         tx_busy_flag_r           <= 1'b0;
         tx_irq_r                 <= 1'b0;
         txd_oe_n_r               <= 1'b1;
      end
      else
      begin
         tx_buffer_pending_flag_r <= serial_output_enable
                                     && (wr_tx || (tx_buffer_pending_flag_r && !tx_load));
         tx_busy_flag_r <= serial_output_enable  // [RULE20]
                           && (wr_tx || tx_buffer_pending_flag_r
                               || (tx_busy_flag_r && !tx_done));  // [RULE19]
         tx_irq_r       <= tx_done;  // [RULE3]
         txd_oe_n_r     <= ~(serial_output_enable
                             && (!input_source_select || port_direction_bit));  // [RULE14]
      end
   end

   // ********************
   // Receiver
   // ********************
   asu_rx_state_e rx_state_r;
   logic [2:0]    rx_tick_r;
   logic [3:0]    rx_count_r;
   logic [7:0]    rx_shift_r;
   logic          rx_busy_flag_r;
   logic          rx_buffer_full_flag_r;
   logic          rx_irq_r;

   wire rx_enable = serial_input_enable && link_run;
   wire rx_sample = (rx_state_r == RX_DATA) && tick && (rx_tick_r == TICK_LAST);  // [RULE24]
   wire rx_char   = rx_count_r < (char8 ? 4'h8 : 4'h7);
   wire rx_done   = rx_sample && (rx_count_r == frame_bits - 4'h1);  // [RULE4]
   // The fourth further low tick after the falling edge comes three to four
   // ticks after it, near half a bit; sampling then lands mid-bit.
   wire rx_found  = (rx_state_r == RX_START) && tick && !serial_in
                    && (rx_tick_r == START_HALF_LAST);  // [RULE2]
   wire [7:0] rx_char_data = char8 ? rx_shift_r : {1'b0, rx_shift_r[6:0]};
   wire [7:0] rx_data_now  = first_lsb ? asu_rev(rx_shift_r, char8) : rx_char_data;  // [RULE12]

   // The receiver shares only mode fields and the baud tick with the transmitter.
   always_ff @(posedge clock_i or posedge reset_i)  // [RULE5]
   begin
      if (reset_i)
      begin
         rx_state_r <= RX_IDLE;
         rx_tick_r  <= 3'h0;
         rx_count_r <= 4'h0;
         rx_shift_r <= 8'h00;
      end
      else if (!rx_enable)
      begin
         rx_state_r <= RX_IDLE;
         rx_tick_r  <= 3'h0;
      end
      else
      begin
         unique case (rx_state_r)
            RX_IDLE:
            begin
               rx_tick_r <= 3'h0;
               if (!serial_in)
               begin
                  rx_state_r <= RX_START;
               end
            end
            RX_START:
            begin
               if (tick && serial_in)
               begin
                  rx_state_r <= RX_IDLE;  // [RULE2]
               end
               else if (rx_found)
               begin
                  rx_state_r <= RX_DATA;
                  rx_tick_r  <= 3'h0;
                  rx_count_r <= 4'h0;  // [RULE4]
               end
               else if (tick)
               begin
                  rx_tick_r <= rx_tick_r + 3'h1;
               end
            end
            RX_DATA:
            begin
               if (tick)
               begin
                  rx_tick_r <= rx_tick_r + 3'h1;
               end
               if (rx_done)
               begin
                  rx_state_r <= RX_IDLE;
               end
               else if (rx_sample)
               begin
                  rx_count_r <= rx_count_r + 4'h1;
                  if (rx_char)
                  begin
                     rx_shift_r <= {rx_shift_r[6:0], serial_in};  // [RULE8]
                  end
               end
            end
         endcase
      end
   end

   // A completion in the same cycle as a buffer read leaves the flag set.
   always_ff @(posedge clock_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         rx_busy_flag_r        <= 1'b0;
         rx_buffer_full_flag_r <= 1'b0;
         rx_data_buffer_r      <= 8'h00;
         rx_irq_r              <= 1'b0;
      end
      else
      begin
         rx_busy_flag_r        <= rx_enable  // [RULE18]
                                  && (rx_found || (rx_busy_flag_r && !rx_done));  // [RULE17]
         rx_buffer_full_flag_r <= (rx_enable && rx_done)  // [RULE15]
                                  || (rx_buffer_full_flag_r && !rd_rx);  // [RULE16]
         rx_data_buffer_r      <= (rx_enable && rx_done) ? rx_data_now : rx_data_buffer_r;
         rx_irq_r              <= rx_enable && rx_done;  // [RULE4]
      end
   end

   // ********************
   // Read-back
   // ********************
   wire [7:0] status_w = {4'h0,
                          tx_buffer_pending_flag_r,
                          rx_buffer_full_flag_r,
                          tx_busy_flag_r,
                          rx_busy_flag_r};

   wire [7:0] rd_mux =
      (reg_addr_i == ADDR_TX_DATA)  ? tx_data_buffer_r      :
      (reg_addr_i == ADDR_RX_DATA)  ? rx_data_buffer_r      :
      (reg_addr_i == ADDR_MODE0)    ? {mode0_r[7:3], sync_bit_count_field} :
      (reg_addr_i == ADDR_MODE1)    ? serial_mode_reg_one_r :
      (reg_addr_i == ADDR_MODE2)    ? serial_mode_reg_two_r :
      (reg_addr_i == ADDR_STATUS)   ? status_w              :
      (reg_addr_i == ADDR_BAUD)     ? baud_r                : port_dir_r;

   always_ff @(posedge clock_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         rdata_r <= 8'h00;
      end
      else
      begin
         rdata_r <= reg_rd_i ? rd_mux : 8'h00;
      end
   end

   assign reg_rdata_o       = rdata_r;
   assign txd_o             = tx_frame_r[0];  // [RULE23]
   assign txd_oe_n_o        = txd_oe_n_r;
   assign tx_complete_irq_o = tx_irq_r;
   assign rx_complete_irq_o = rx_irq_r;

endmodule : asu_uart
`default_nettype wire

//--- inc/asu_pkg.sv
// Constants, register map and state types of the asynchronous serial channel.
package asu_pkg;

   // ********************
   // Bus and frame widths
   // ********************
   localparam int ASU_AW      = 3;
   localparam int ASU_DW      = 8;
   localparam int ASU_FRAME_W = 12;

   // ********************
   // Register offsets
   // ********************
   localparam logic [2:0] ADDR_TX_DATA  = 3'h0;
   localparam logic [2:0] ADDR_RX_DATA  = 3'h1;
   localparam logic [2:0] ADDR_MODE0    = 3'h2;
   localparam logic [2:0] ADDR_MODE1    = 3'h3;
   localparam logic [2:0] ADDR_MODE2    = 3'h4;
   localparam logic [2:0] ADDR_STATUS   = 3'h5;
   localparam logic [2:0] ADDR_BAUD     = 3'h6;
   localparam logic [2:0] ADDR_PORT_DIR = 3'h7;

   // ********************
   // Field positions
   // ********************
   localparam int MODE0_SYNC_CNT_LSB = 0;
   localparam int MODE0_FIRST_LSB    = 4;
   localparam int MODE1_COMM_TYPE    = 0;
   localparam int MODE1_CLK_MASTER   = 2;
   localparam int MODE1_OUT_EN       = 4;
   localparam int MODE1_IN_EN        = 5;
   localparam int MODE1_IN_SOURCE    = 7;
   localparam int MODE2_FRAME_LO     = 0;
   localparam int MODE2_FRAME_HI     = 1;
   localparam int MODE2_PARITY_LO    = 3;
   localparam int MODE2_PARITY_HI    = 4;
   localparam int MODE2_PARITY_DIS   = 5;
   localparam int STAT_RX_BUSY       = 0;
   localparam int STAT_TX_BUSY       = 1;
   localparam int STAT_RX_FULL       = 2;
   localparam int STAT_TX_PENDING    = 3;
   localparam int PORT_DIR_TXD       = 0;

   // ********************
   // Reset values
   // ********************
   localparam logic [7:0] MODE0_RST    = 8'h00;
   localparam logic [7:0] MODE1_RST    = 8'h00;
   localparam logic [7:0] MODE2_RST    = 8'h00;
   localparam logic [7:0] BAUD_RST     = 8'h00;
   localparam logic [7:0] PORT_DIR_RST = 8'h00;

   // ********************
   // Bit timing: eight oversampling ticks to one bit
   // ********************
   localparam logic [2:0] TICK_LAST       = 3'h7;
   localparam logic [2:0] START_HALF_LAST = 3'h3;

   // ********************
   // State types
   // ********************
   typedef enum logic [1:0] {
      TX_IDLE  = 2'b01,
      TX_SHIFT = 2'b10
   } asu_tx_state_e;

   typedef enum logic [2:0] {
      RX_IDLE  = 3'b001,
      RX_START = 3'b010,
      RX_DATA  = 3'b100
   } asu_rx_state_e;

endpackage : asu_pkg

//--- inc/asu_baud_if.sv
// Link between the channel and its baud-rate timer.
`timescale 1ns/100ps
`default_nettype none
interface asu_baud_if;
   logic [7:0] reload;
   logic       run;
   logic       tick;

   modport gen
   (
      input  reload,
      input  run,
      output tick
   );

   modport user
   (
      output reload,
      output run,
      input  tick
   );
endinterface : asu_baud_if
`default_nettype wire

//--- core/asu_baud.sv
// Baud-rate timer giving the eight-per-bit oversampling tick.
`timescale 1ns/100ps
`default_nettype none
module asu_baud
(
   // Clock and reset
   input  wire logic clock_i,
   input  wire logic reset_i,
   // Tick link
   asu_baud_if.gen   baud
);
   import asu_pkg::*;

   logic [7:0] count_r;
   logic       half_r;
   logic       tick_r;

   wire overflow = (count_r == baud.reload);

   // One tick every second overflow, eight ticks per bit, so a bit is
   // the overflow period times 2 times 8.
   always_ff @(posedge clock_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         count_r <= 8'h00;
         half_r  <= 1'b0;
         tick_r  <= 1'b0;
      end
      else if (!baud.run)
      begin
         count_r <= 8'h00;
         half_r  <= 1'b0;
         tick_r  <= 1'b0;
      end
      else
      begin
         count_r <= overflow ? 8'h00 : count_r + 8'h01;
         half_r  <= overflow ? ~half_r : half_r;  // [RULE22]
         tick_r  <= overflow & half_r;            // [RULE22]
      end
   end

   assign baud.tick = tick_r;

endmodule : asu_baud
`default_nettype wire

//--- bench/asu_uart_monitor.sv
// Port checker of the asynchronous serial channel.
`timescale 1ns/100ps
`default_nettype none
module asu_uart_monitor
   import asu_pkg::*;
(
   input wire logic       clock_i,
   input wire logic       reset_i,
   input wire logic [2:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic       reg_wr_i,
   input wire logic       reg_rd_i,
   input wire logic [7:0] reg_rdata_o,
   input wire logic       txd_i,
   input wire logic       txd_o,
   input wire logic       txd_oe_n_o,
   input wire logic       rxd_i,
   input wire logic       tx_complete_irq_o,
   input wire logic       rx_complete_irq_o
);
   logic [7:0] mode1_r;
   logic       dir_r;
   logic       act_r;
   logic       pend_r;
   wire  logic wr_m1 = reg_wr_i && reg_addr_i == ADDR_MODE1;
   wire  logic wr_pd = reg_wr_i && reg_addr_i == ADDR_PORT_DIR;
   wire  logic go = reg_wr_i && reg_addr_i == ADDR_TX_DATA && mode1_r[4];
   wire  logic link = mode1_r[0] && mode1_r[2];
   wire  logic oe_x = !(mode1_r[4] && (!mode1_r[7] || dir_r));
   // A byte written mid-frame chains on, so the frame flag survives one completion.
   always_ff @(posedge clock_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         mode1_r <= 8'h00;
         dir_r   <= 1'b0;
         act_r   <= 1'b0;
         pend_r  <= 1'b0;
      end
      else
      begin
         if (wr_m1) mode1_r <= reg_wdata_i;
         if (wr_pd) dir_r <= reg_wdata_i[0];
         if (go) act_r <= 1'b1;
         else if (tx_complete_irq_o) act_r <= pend_r;
         if (go && act_r) pend_r <= 1'b1;
         else if (tx_complete_irq_o) pend_r <= 1'b0;
      end
   end
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (reset_i);
   property p_rd_quiet; !reg_rd_i |=> reg_rdata_o == 8'h00; endproperty
   a_rd_quiet: assert property (p_rd_quiet) else $error("read data not cleared");
   property p_start; go && link && !act_r |-> ##[1:4] !txd_o; endproperty
   a_start: assert property (p_start) else $error("no start bit");
   property p_stop; tx_complete_irq_o |-> $past(txd_o); endproperty
   a_stop: assert property (p_stop) else $error("stop bit not high");
   property p_tx_end; tx_complete_irq_o |-> act_r ##1 !tx_complete_irq_o; endproperty
   a_tx_end: assert property (p_tx_end) else $error("bad transmit pulse");
   property p_rx_end; rx_complete_irq_o |-> mode1_r[5] ##1 !rx_complete_irq_o; endproperty
   a_rx_end: assert property (p_rx_end) else $error("bad receive pulse");
   property p_off; !mode1_r[4] [*3] |-> txd_o && txd_oe_n_o && !tx_complete_irq_o; endproperty
   a_off: assert property (p_off) else $error("output not idle");
   property p_oe; !(wr_m1 || wr_pd) [*2] |-> txd_oe_n_o == oe_x; endproperty
   a_oe: assert property (p_oe) else $error("pin direction wrong");
   property p_link; !link [*2] |-> !tx_complete_irq_o && !rx_complete_irq_o; endproperty
   a_link: assert property (p_link) else $error("traffic without timer");
   c_tx: cover property (tx_complete_irq_o);
   c_rx: cover property (rx_complete_irq_o);
   c_abort: cover property (wr_m1 && !reg_wdata_i[4] && act_r);
endmodule : asu_uart_monitor
bind asu_uart asu_uart_monitor i_asu_uart_monitor (.*);
`default_nettype wire

//--- bench/asu_remote.sv
// Remote transceiver at the far end of the serial line.
`timescale 1ns/100ps
`default_nettype none
module asu_remote
#(
   parameter int BIT = 32
)
(
   input  wire logic       clock_i,
   input  wire logic       line_i,
   input  wire logic [5:0] fmt_i,
   output logic            rxd_o
);
   initial rxd_o = 1'b1;
   // The frame starts at bit 0; the tail past the stops stays at the idle level.
   function automatic logic [11:0] frame(input logic [7:0] d, input logic [5:0] f);
      logic [11:0] v;
      logic        p;
      int          k;
      v = 12'hffe;
      k = 1;
      p = f[3] ? ^d[6:0] ^ (f[1] & d[7]) ^ !f[2] : f[2];
      for (int i = 0; i < 8; i++)
         if (i < 7 || f[1])
         begin
            v[k] = f[5] ? d[i] : d[(f[1] ? 7 : 6) - i];
            k++;
         end
      if (!f[4]) v[k] = p;
      return v;
   endfunction : frame
   task automatic send(input logic [7:0] d);
      logic [11:0] v;
      v = frame(d, fmt_i);
      for (int i = 0; i < 12; i++)
      begin
         rxd_o <= v[i];
         repeat (BIT) @(posedge clock_i);
      end
   endtask : send
   task automatic recv(output logic [11:0] v);
      @(negedge line_i);
      repeat (BIT / 2) @(posedge clock_i);
      for (int i = 0; i < 12; i++)
      begin
         v[i] = line_i;
         repeat (BIT) @(posedge clock_i);
      end
   endtask : recv
endmodule : asu_remote
`default_nettype wire

//--- bench/asu_uart_tb.sv
// Self-checking bench of the asynchronous serial channel.
`timescale 1ns/100ps
`default_nettype none
`define check(n, e, s) begin compares++; if ((s) !== (e)) begin failures++; \
   $display("CHECK FAILED %s exp %h got %h", n, e, s); end end
module asu_uart_tb;
   import asu_pkg::*;
   logic        clock_i = 1'b0;
   logic        reset_i = 1'b1;
   logic [2:0]  reg_addr_i = 3'h0;
   logic [7:0]  reg_wdata_i = 8'h00;
   logic        reg_wr_i = 1'b0;
   logic        reg_rd_i = 1'b0;
   logic [7:0]  reg_rdata_o;
   logic        txd_o;
   logic        txd_oe_n_o;
   logic        rxd;
   logic        tx_irq;
   logic        rx_irq;
   logic [5:0]  fmt = 6'h00;
   logic [11:0] got;
   logic [7:0]  rd;
   int          failures = 0;
   int          compares = 0;
   int          cyc = 0;
   int          tx_n = 0;
   int          rx_n = 0;
   // The shared pin has a pull-up, so a released pin reads high.
   wire  logic  line = txd_oe_n_o ? 1'b1 : txd_o;
   asu_uart i_asu_uart (.clock_i(clock_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
      .reg_rdata_o(reg_rdata_o), .txd_i(line), .txd_o(txd_o), .txd_oe_n_o(txd_oe_n_o),
      .rxd_i(rxd), .tx_complete_irq_o(tx_irq), .rx_complete_irq_o(rx_irq));
   asu_remote #(.BIT(32)) i_asu_remote (.clock_i(clock_i), .line_i(line), .fmt_i(fmt),
      .rxd_o(rxd));
   always #2 clock_i = ~clock_i;
   always @(posedge clock_i)
   begin
      cyc++;
      tx_n += tx_irq;
      rx_n += rx_irq;
      if (cyc == 30000)
      begin
         failures++;
         results();
      end
   end
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      reg_addr_i  <= a;
      reg_wdata_i <= d;
      reg_wr_i    <= 1'b1;
      @(posedge clock_i);
      reg_wr_i    <= 1'b0;
      @(posedge clock_i);
   endtask : wr
   task automatic rdc(input logic [2:0] a, input logic [7:0] e);
      reg_addr_i <= a;
      reg_rd_i   <= 1'b1;
      @(posedge clock_i);
      reg_rd_i   <= 1'b0;
      #1 rd = reg_rdata_o;
      `check("rdata", e, rd)
      @(posedge clock_i);
   endtask : rdc
   task automatic results;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : results
   initial
   begin
      repeat (3) @(posedge clock_i);
      reset_i <= 1'b0;
      @(posedge clock_i);
      rdc(ADDR_MODE1, MODE1_RST);
      wr(ADDR_STATUS, 8'hff);
      rdc(ADDR_STATUS, 8'h00);
      wr(ADDR_BAUD, 8'h01);
      wr(ADDR_MODE1, 8'h35);
      for (int m = 0; m < 5; m++)
      begin
         fmt = {m[0], m == 4, m[1:0], m[1:0]};
         wr(ADDR_MODE0, {3'h0, m[0], 4'h5});
         wr(ADDR_MODE2, {2'h0, fmt[4:2], 1'b0, fmt[1:0]});
         fork
            i_asu_remote.recv(got);
            begin
               wr(ADDR_TX_DATA, 8'h96 ^ m[7:0]);
               i_asu_remote.send(8'h3c + m[7:0]);
            end
         join
         `check("frame", i_asu_remote.frame(8'h96 ^ m[7:0], fmt), got)
         rdc(ADDR_RX_DATA, (8'h3c + m[7:0]) & {fmt[1], 7'h7f});
         rdc(ADDR_STATUS, 8'h00);
      end
      `check("tx count", 5, tx_n)
      `check("rx count", 5, rx_n)
      wr(ADDR_TX_DATA, 8'h0f);
      rdc(ADDR_STATUS, 8'h02);
      wr(ADDR_MODE1, 8'h05);
      rdc(ADDR_STATUS, 8'h00);
      wr(ADDR_MODE1, 8'hb5);
      #1 `check("pin off", 1'b1, txd_oe_n_o)
      wr(ADDR_PORT_DIR, 8'h01);
      #1 `check("pin on", 1'b0, txd_oe_n_o)
      results();
   end
endmodule : asu_uart_tb
`default_nettype wire
